// *** logic/tws_slave_rx.sv ***
// two-wire slave receiver with AHB-Lite register access
// assumes scl/sda pins arrive asynchronously; the bus pads resolve open drain
`timescale 1ns/100ps
`default_nettype none
module tws_slave_rx
	import tws_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        srst_i,
	input  wire logic        ce_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	input  wire logic        deep_sleep_i,
	input  wire logic        arb_lost_i,
	output logic             wake_o
);

	// ==================================================================
	// register bus slave
	tws_aphase_s aph_r;
	tws_ctrl_s   ctrl_r;
	logic [7:0]  own_addr_r;
	logic [7:0]  data_r;
	logic [7:0]  status_r;
	logic [1:0]  presc_r;

	wire         bus_take = hsel_i & htrans_i[1] & hready_i;
	tws_aphase_s aph_nxt;
	logic [27:0] aph_hi_r;
	assign aph_nxt = {bus_take & ~hwrite_i, bus_take & hwrite_i, haddr_i[3:0]};

	// upper address bits travel with the phase so unmapped writes are dropped
	wire upper_zero = (aph_hi_r == 28'h0000000);
	wire wr_osa  = aph_r.wr & upper_zero & (aph_r.ofs == TWS_OFS_OWN_ADDR);
	wire wr_ctrl = aph_r.wr & upper_zero & (aph_r.ofs == TWS_OFS_CONTROL);
	wire wr_stat = aph_r.wr & upper_zero & (aph_r.ofs == TWS_OFS_STATUS);
	wire wr_data = aph_r.wr & upper_zero & (aph_r.ofs == TWS_OFS_DATA);

	// reads take one wait state so a write just before is always seen
	wire [7:0] rd_mux =
		(aph_r.ofs == TWS_OFS_OWN_ADDR) ? own_addr_r :
		(aph_r.ofs == TWS_OFS_CONTROL)  ? ctrl_r :
		(aph_r.ofs == TWS_OFS_STATUS)   ? {status_r[7:2], presc_r} :
		(aph_r.ofs == TWS_OFS_DATA)     ? data_r : 8'h00;

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			aph_r       <= '0;
			aph_hi_r    <= 28'h0000000;
			hreadyout_o <= 1'b1;
			hrdata_o    <= 32'h00000000;
			hresp_o     <= 1'b0;
		end else if (ce_i) begin
			aph_r       <= hreadyout_o ? aph_nxt : '0;
			aph_hi_r    <= haddr_i[31:4];
			hreadyout_o <= ~(hreadyout_o & aph_nxt.rd);
			if (aph_r.rd) begin
				hrdata_o <= {24'h000000, upper_zero ? rd_mux : 8'h00};
			end
		end
	end

	// ==================================================================
	// pin synchronisers and bus conditions
	logic scl_s1_r, scl_s2_r, scl_q_r;
	logic sda_s1_r, sda_s2_r, sda_q_r;

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			{scl_s1_r, scl_s2_r, scl_q_r} <= 3'b111;
			{sda_s1_r, sda_s2_r, sda_q_r} <= 3'b111;
		end else if (ce_i) begin
			scl_s1_r <= scl_i;
			scl_s2_r <= scl_s1_r;
			scl_q_r  <= scl_s2_r;
			sda_s1_r <= sda_i;
			sda_s2_r <= sda_s1_r;
			sda_q_r  <= sda_s2_r;
		end
	end

	wire scl_rise = scl_s2_r & ~scl_q_r;
	wire scl_fall = ~scl_s2_r & scl_q_r;
	wire bus_start = scl_s2_r & scl_q_r & sda_q_r & ~sda_s2_r;
	wire bus_stop  = scl_s2_r & scl_q_r & ~sda_q_r & sda_s2_r;

	// ==================================================================
	// receive engine
	tws_state_e  st_r, st_nxt;
	logic [7:0]  shift_r;
	logic [3:0]  cnt_r;
	logic        gc_mode_r;
	logic        ack_next_r;
	logic        to_idle_r;
	logic        flag_set;
	logic [7:0]  code_nxt;

	wire own_hit = (shift_r[7:1] == own_addr_r[7:1]);
	wire gc_hit  = (shift_r == TWS_GC_ADDR) & own_addr_r[TWS_OSA_GCE_POS];
	// ack enable gates the address response here and the data ack below; monitoring continues regardless
	wire may_ack = ctrl_r.interface_enable & ctrl_r.acknowledge_enable;
	wire addr_hit = may_ack & (own_hit | gc_hit);
	wire byte_done = (cnt_r == TWS_BYTE_BITS);
	wire addressed = (st_r == TWS_DATA) | (st_r == TWS_DATA_ACK) |
		((st_r == TWS_HOLD) & ~to_idle_r);
	wire stop_seen = (bus_stop | bus_start) & addressed;
	wire flag_clr  = wr_ctrl & hwdata_i[TWS_CTRL_FLAG_POS];

	wire [7:0] addr_code = gc_mode_r ?
		(arb_lost_i ? TWS_ST_ARB_GC : TWS_ST_GC_ACK) :
		(arb_lost_i ? TWS_ST_ARB_OWN : TWS_ST_OWN_ACK);
	wire [7:0] data_code = gc_mode_r ?
		(ack_next_r ? TWS_ST_GC_DACK : TWS_ST_GC_DNAK) :
		(ack_next_r ? TWS_ST_OWN_DACK : TWS_ST_OWN_DNAK);

	always_comb begin
		st_nxt   = st_r;
		flag_set = 1'b0;
		code_nxt = status_r;
		unique case (st_r)
			TWS_IDLE: begin
				if (bus_start) begin
					st_nxt = TWS_ADDR;
				end
			end
			TWS_ADDR: begin
				if (bus_start) begin
					st_nxt = TWS_ADDR;
				end else if (bus_stop) begin
					st_nxt = TWS_IDLE;
				end else if (scl_fall & byte_done) begin
					st_nxt = addr_hit ? TWS_ADDR_ACK : TWS_IDLE;
				end
			end
			TWS_ADDR_ACK: begin
				if (scl_fall) begin
					if (shift_r[0]) begin
						st_nxt = TWS_XMIT;
					end else begin
						st_nxt   = TWS_HOLD;
						flag_set = 1'b1;
						code_nxt = addr_code;
					end
				end
			end
			TWS_DATA: begin
				if (stop_seen) begin
					st_nxt   = bus_start ? TWS_ADDR : TWS_HOLD;
					flag_set = 1'b1;
					code_nxt = TWS_ST_STOP;
				end else if (scl_fall & byte_done) begin
					st_nxt = TWS_DATA_ACK;
				end
			end
			TWS_DATA_ACK: begin
				if (scl_fall) begin
					st_nxt   = TWS_HOLD;
					flag_set = 1'b1;
					code_nxt = data_code;
				end
			end
			TWS_HOLD: begin
				if (stop_seen) begin
					st_nxt   = bus_start ? TWS_ADDR : TWS_HOLD;
					flag_set = 1'b1;
					code_nxt = TWS_ST_STOP;
				end else if (~ctrl_r.interrupt_flag) begin
					st_nxt = to_idle_r ? TWS_IDLE : TWS_DATA;
				end
			end
			TWS_XMIT: begin
				// transmit side lives elsewhere; only track the bus here
				if (bus_stop) begin
					st_nxt = TWS_IDLE;
				end else if (bus_start) begin
					st_nxt = TWS_ADDR;
				end
			end
			default: begin
				st_nxt = TWS_IDLE;
			end
		endcase
		if (~ctrl_r.interface_enable) begin
			st_nxt   = TWS_IDLE;
			flag_set = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			st_r       <= TWS_IDLE;
			shift_r    <= 8'h00;
			cnt_r      <= 4'h0;
			gc_mode_r  <= 1'b0;
			ack_next_r <= 1'b0;
			to_idle_r  <= 1'b0;
			status_r   <= TWS_ST_NONE;
		end else if (ce_i) begin
			st_r <= st_nxt;
			if (flag_set) begin
				status_r <= code_nxt;
			end else if ((st_r == TWS_HOLD) & (st_nxt != TWS_HOLD)) begin
				status_r <= TWS_ST_NONE;
			end
			if (bus_start | (st_nxt == TWS_DATA & st_r != TWS_DATA)) begin
				cnt_r <= 4'h0;
			end else if (scl_rise & ~byte_done) begin
				shift_r <= {shift_r[6:0], sda_s2_r};
				cnt_r   <= cnt_r + 4'h1;
			end
			if (st_r == TWS_ADDR & st_nxt == TWS_ADDR_ACK) begin
				gc_mode_r <= ~own_hit;
			end
			// ack decision sampled at end of byte, so a late clear of ack enable still acks it
			if (st_r == TWS_DATA & st_nxt == TWS_DATA_ACK) begin
				ack_next_r <= ctrl_r.acknowledge_enable;
			end
			if (flag_set) begin
				to_idle_r <= (st_r == TWS_DATA_ACK) ? ~ack_next_r : (code_nxt == TWS_ST_STOP);
			end
		end
	end

	// ==================================================================
	// pin drivers, open drain: level always low, enable pulls
	wire sda_pull_nxt = (st_nxt == TWS_ADDR_ACK) |
		((st_nxt == TWS_DATA_ACK) & ((st_r == TWS_DATA_ACK) ? ack_next_r :
		ctrl_r.acknowledge_enable));
	wire scl_pull_nxt = (st_nxt == TWS_HOLD) & (flag_set | ctrl_r.interrupt_flag) &
		~(stop_seen | (to_idle_r & ~flag_set & (code_nxt == TWS_ST_STOP)));

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			sda_o    <= 1'b0;
			scl_o    <= 1'b0;
			sda_oe_o <= 1'b0;
			scl_oe_o <= 1'b0;
		end else if (ce_i) begin
			sda_oe_o <= sda_pull_nxt;
			scl_oe_o <= scl_pull_nxt & (status_r != TWS_ST_STOP | flag_set) &
				(code_nxt != TWS_ST_STOP);
		end
	end

	// ==================================================================
	// software registers
	tws_ctrl_s ctrl_nxt;
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			ctrl_nxt                    = tws_ctrl_s'(hwdata_i[7:0]);
			ctrl_nxt.interrupt_flag     = ctrl_r.interrupt_flag & ~flag_clr;
			ctrl_nxt.write_collision_flag = ctrl_r.write_collision_flag;
			ctrl_nxt.reserved           = 1'b0;
		end
		if (wr_data) begin
			ctrl_nxt.write_collision_flag = ~ctrl_r.interrupt_flag;
		end
		if (flag_set) begin
			ctrl_nxt.interrupt_flag = 1'b1;                              // set beats clear
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ctrl_r     <= tws_ctrl_s'(TWS_RST_CONTROL);
			own_addr_r <= TWS_RST_OWN_ADDR;
			presc_r    <= TWS_RST_PRESC;
			data_r     <= TWS_RST_DATA;
			wake_o     <= 1'b0;
		end else if (ce_i) begin
			ctrl_r <= ctrl_nxt;
			if (wr_osa) begin
				own_addr_r <= hwdata_i[7:0];
			end
			if (wr_stat) begin
				presc_r <= hwdata_i[1:0];
			end
			// received data bytes and software writes made while the flag is set land here, never the address byte
			if (st_r == TWS_DATA & st_nxt == TWS_DATA_ACK) begin
				data_r <= shift_r;
			end else if (wr_data & ctrl_r.interrupt_flag) begin
				data_r <= hwdata_i[7:0];
			end
			if (flag_set & deep_sleep_i & (st_r == TWS_ADDR_ACK)) begin
				wake_o <= 1'b1;
			end else if (~ctrl_nxt.interrupt_flag) begin
				wake_o <= 1'b0;
			end
		end
	end

	// ==================================================================
	// checks
	own_match_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		(ce_i && st_r == TWS_ADDR && scl_fall && byte_done && !bus_start && !bus_stop
		&& !(own_hit || gc_hit)) |=> st_r == TWS_IDLE)
		else $error("unmatched address was accepted");

	gc_enable_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		(st_r == TWS_ADDR_ACK && gc_mode_r) |-> own_addr_r[0])
		else $error("general call taken while disabled");

	ack_gate_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		(ce_i && st_r == TWS_ADDR && st_nxt == TWS_ADDR_ACK) |-> may_ack ##1 sda_oe_o)
		else $error("address ack without ack enable");

	addr_flag_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		(ce_i && st_r == TWS_ADDR_ACK && scl_fall && !shift_r[0] && ctrl_r.interface_enable)
		|=> ctrl_r.interrupt_flag && (status_r[7:4] == 4'h6 || status_r[7:4] == 4'h7))
		else $error("address received without flag and status");

	data_nack_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		(ce_i && st_r == TWS_DATA && st_nxt == TWS_DATA_ACK &&
		!ctrl_r.acknowledge_enable) |=> !sda_oe_o && !ack_next_r)
		else $error("nack byte was acknowledged");

	hold_scl_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		(st_r == TWS_HOLD && ctrl_r.interrupt_flag && status_r != TWS_ST_STOP)[*2]
		|-> scl_oe_o)
		else $error("clock not stretched while flag set");

	hold_release_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		(ce_i && st_r == TWS_HOLD && !ctrl_r.interrupt_flag && !stop_seen) |=> ##1 !scl_oe_o)
		else $error("clock held after flag clear");

	wake_hold_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		(wake_o && ctrl_r.interrupt_flag && !flag_clr) |=> wake_o)
		else $error("wake dropped before flag clear");

	ctrl_reset_a: assert property (@(posedge core_clk_i)
		srst_i |=> (ctrl_r == tws_ctrl_s'(TWS_RST_CONTROL)) && !scl_oe_o && !sda_oe_o)
		else $error("control not cleared by reset");

endmodule
`default_nettype wire

// *** logic/tws_pkg.sv ***
// constants, register map and carrier types of the two-wire slave receiver
// assumes a 200 MHz core clock and a 32-bit AHB-Lite register bus
`default_nettype none
package tws_pkg;

	// ==================================================================
	// register map, byte addresses
	localparam logic [3:0] TWS_OFS_OWN_ADDR = 4'h0;
	localparam logic [3:0] TWS_OFS_CONTROL  = 4'h4;
	localparam logic [3:0] TWS_OFS_STATUS   = 4'h8;
	localparam logic [3:0] TWS_OFS_DATA     = 4'hC;

	// ==================================================================
	// reset values
	localparam logic [7:0] TWS_RST_OWN_ADDR = 8'h00;
	localparam logic [7:0] TWS_RST_CONTROL  = 8'h00;
	localparam logic [7:0] TWS_RST_DATA     = 8'hFF;
	localparam logic [1:0] TWS_RST_PRESC    = 2'h0;

	// ==================================================================
	// field positions
	localparam int TWS_CTRL_FLAG_POS  = 7;
	localparam int TWS_OSA_GCE_POS    = 0;
	localparam int TWS_STAT_CODE_LSB  = 3;

	// ==================================================================
	// bus values and status codes
	localparam logic [7:0] TWS_GC_ADDR     = 8'h00;
	localparam logic [3:0] TWS_BYTE_BITS   = 4'h8;
	localparam logic [7:0] TWS_ST_NONE     = 8'hF8;
	localparam logic [7:0] TWS_ST_OWN_ACK  = 8'h60;
	localparam logic [7:0] TWS_ST_ARB_OWN  = 8'h68;
	localparam logic [7:0] TWS_ST_GC_ACK   = 8'h70;
	localparam logic [7:0] TWS_ST_ARB_GC   = 8'h78;
	localparam logic [7:0] TWS_ST_OWN_DACK = 8'h80;
	localparam logic [7:0] TWS_ST_OWN_DNAK = 8'h88;
	localparam logic [7:0] TWS_ST_GC_DACK  = 8'h90;
	localparam logic [7:0] TWS_ST_GC_DNAK  = 8'h98;
	localparam logic [7:0] TWS_ST_STOP     = 8'hA0;

	// ==================================================================
	// types
	typedef enum logic [2:0] {
		TWS_IDLE     = 3'b000,
		TWS_ADDR     = 3'b001,
		TWS_ADDR_ACK = 3'b010,
		TWS_DATA     = 3'b011,
		TWS_DATA_ACK = 3'b100,
		TWS_HOLD     = 3'b101,
		TWS_XMIT     = 3'b110
	} tws_state_e;

	// layout matches the serial_control register bit for bit
	typedef struct packed {
		logic interrupt_flag;
		logic acknowledge_enable;
		logic start_request;
		logic stop_request;
		logic write_collision_flag;
		logic interface_enable;
		logic reserved;
		logic interrupt_enable;
	} tws_ctrl_s;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [3:0] ofs;
	} tws_aphase_s;

endpackage
`default_nettype wire

// *** verification/tws_bus_master.sv ***
// two-wire bus master transmitter model, open drain on both wires
// assumes the bench resolves scl and sda with pull-ups
`timescale 1ns/100ps
`default_nettype none
module tws_bus_master #(
	parameter int HALF_NS = 24
) (
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_low_o,
	output logic      sda_low_o
);
	// ==================================================================
	// idle: both wires released, scl stands still high between frames
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end

	// ==================================================================
	// sda moves a quarter period after scl falls, never near a high scl
	task automatic clock_bit(input logic b, output logic s);
		#(HALF_NS / 2);
		sda_low_o = ~b;
		#(HALF_NS / 2);
		scl_low_o = 1'b0;
		// slave may stretch; the bench watchdog bounds this
		wait (scl_i === 1'b1);
		#HALF_NS;
		s = sda_i;
		scl_low_o = 1'b1;
	endtask

	task automatic start();
		sda_low_o = 1'b1;
		#HALF_NS;
		scl_low_o = 1'b1;
	endtask

	task automatic stop();
		#(HALF_NS / 2);
		sda_low_o = 1'b1;
		#(HALF_NS / 2);
		scl_low_o = 1'b0;
		wait (scl_i === 1'b1);
		#HALF_NS;
		sda_low_o = 1'b0;
		#HALF_NS;
	endtask

	// msb first, then the ninth clock reads the slave's answer
	task automatic send_byte(input logic [7:0] b, output logic nak);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(b[i], s);
		end
		clock_bit(1'b1, nak);
	endtask
endmodule
`default_nettype wire

// *** verification/two_wire_slave_receiver_tb.sv ***
// self-checking bench for the two-wire slave receiver
// assumes one AHB-Lite slave on the bus and a master model on the wires
`timescale 1ns/100ps
`default_nettype none
module two_wire_slave_receiver_tb;
	import tws_pkg::*;
	localparam logic [7:0] A_OWN = {4'h0, TWS_OFS_OWN_ADDR};
	localparam logic [7:0] A_CTL = {4'h0, TWS_OFS_CONTROL};
	localparam logic [7:0] A_STA = {4'h0, TWS_OFS_STATUS};
	localparam logic [7:0] A_DAT = {4'h0, TWS_OFS_DATA};
	logic        clk, srst, hsel, hwrite, deep_sleep, arb_lost, gc;
	logic [31:0] haddr, hwdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [6:0]  own;
	logic [7:0]  q, b;
	wire  [31:0] hrdata;
	wire         hreadyout, scl_oe, sda_oe, wake, m_scl_low, m_sda_low, scl, sda;
	wire         hresp, scl_lvl, sda_lvl;
	int          n_mismatch = 0;
	int          compares = 0;

	// ==================================================================
	// wired-and of both parties with pull-ups
	// the slave's own level counts whenever its enable is up
	assign scl = ~(m_scl_low | (scl_oe & ~scl_lvl));
	assign sda = ~(m_sda_low | (sda_oe & ~sda_lvl));
	always #2.5 clk = ~clk;

	tws_slave_rx DUT (.core_clk_i(clk), .srst_i(srst), .ce_i(1'b1), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
		.hreadyout_o(hreadyout), .hresp_o(hresp), .scl_i(scl), .scl_o(scl_lvl),
		.scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_lvl), .sda_oe_o(sda_oe),
		.deep_sleep_i(deep_sleep),
		.arb_lost_i(arb_lost), .wake_o(wake));
	tws_bus_master m (.scl_i(scl), .sda_i(sda), .scl_low_o(m_scl_low), .sda_low_o(m_sda_low));

	// ==================================================================
	// expectations and comparisons
	function automatic logic [7:0] exp_code(input logic g, input logic arb, input logic dat,
		input logic nak);
		if (dat) begin
			return nak ? (g ? TWS_ST_GC_DNAK : TWS_ST_OWN_DNAK)
				: (g ? TWS_ST_GC_DACK : TWS_ST_OWN_DACK);
		end
		return g ? (arb ? TWS_ST_ARB_GC : TWS_ST_GC_ACK) : (arb ? TWS_ST_ARB_OWN : TWS_ST_OWN_ACK);
	endfunction

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// ==================================================================
	// single word transfer; holds each phase until hready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h0, d};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		q = hrdata[7:0];
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		xfer(1'b0, a, 8'h00);
		chk8(q, exp);
		chk1(hresp | (|hrdata[31:8]), 1'b0);
	endtask

	// polls the flag a bounded number of times, then checks the status
	task automatic wait_flag(input logic [7:0] code);
		int n;
		n = 0;
		q = 8'h00;
		while (q[TWS_CTRL_FLAG_POS] !== 1'b1 && n < 40) begin
			xfer(1'b0, A_CTL, 8'h00);
			n++;
		end
		rdchk(A_STA, code);
	endtask

	task automatic addr(input logic [7:0] a, input logic nak);
		logic s;
		m.start();
		m.send_byte(a, s);
		chk1(s, nak);
	endtask

	task automatic data(input logic [7:0] d, input logic nak);
		logic s;
		m.send_byte(d, s);
		chk1(s, nak);
	endtask

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ==================================================================
	// tests
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		{hsel, hwrite, deep_sleep, arb_lost} = 4'h0;
		{haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		void'($urandom(72425));
		own = 7'($urandom % 126) + 7'h01;
		b = 8'($urandom);
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		rdchk(A_OWN, TWS_RST_OWN_ADDR);
		rdchk(A_CTL, TWS_RST_CONTROL);
		rdchk(A_STA, TWS_ST_NONE);
		rdchk(A_DAT, TWS_RST_DATA);
		addr({own, 1'b0}, 1'b1);
		m.stop();
		wr(A_STA, 8'h03);
		rdchk(A_STA, TWS_ST_NONE | 8'h03);
		wr(A_STA, 8'h00);
		$display("test reset done");
		wr(A_OWN, {own, 1'b0});
		// unmapped word above the map: write dropped, read gives zero
		wr(8'h10, 8'h00);
		rdchk(8'h10, 8'h00);
		rdchk(A_OWN, {own, 1'b0});
		wr(A_CTL, 8'h44);
		addr({own ^ 7'h40, 1'b0}, 1'b1);
		m.stop();
		rdchk(A_STA, TWS_ST_NONE);
		addr({own, 1'b0}, 1'b0);
		wait_flag(TWS_ST_OWN_ACK);
		chk1(scl_oe, 1'b1);
		for (int k = 0; k < 3; k++) begin
			b = (k == 0) ? 8'hFF : 8'($urandom);
			wr(A_CTL, 8'hC4);
			data(b, 1'b0);
			wait_flag(exp_code(1'b0, 1'b0, 1'b1, 1'b0));
			rdchk(A_DAT, b);
		end
		// ack enable dropped together with the clear
		wr(A_CTL, 8'h84);
		data(~b, 1'b1);
		wait_flag(exp_code(1'b0, 1'b0, 1'b1, 1'b1));
		wr(A_CTL, 8'h84);
		m.stop();
		rdchk(A_STA, TWS_ST_NONE);
		addr({own, 1'b0}, 1'b1);
		m.stop();
		wr(A_CTL, 8'h44);
		addr({own, 1'b0}, 1'b0);
		wait_flag(TWS_ST_OWN_ACK);
		wr(A_CTL, 8'hC4);
		m.stop();
		wait_flag(TWS_ST_STOP);
		chk1(scl_oe, 1'b0);
		wr(A_CTL, 8'hC4);
		rdchk(A_STA, TWS_ST_NONE);
		$display("test own receive done");
		wr(A_OWN, {own, 1'b1});
		for (int i = 0; i < 4; i++) begin
			gc = i[0];
			@(posedge clk);
			arb_lost <= i[1];
			addr(gc ? TWS_GC_ADDR : {own, 1'b0}, 1'b0);
			wait_flag(exp_code(gc, i[1], 1'b0, 1'b0));
			arb_lost <= 1'b0;
			wr(A_CTL, 8'hC4);
			b = 8'($urandom);
			data(b, 1'b0);
			wait_flag(exp_code(gc, 1'b0, 1'b1, 1'b0));
			rdchk(A_DAT, b);
			wr(A_CTL, 8'hC4);
			m.stop();
			wait_flag(TWS_ST_STOP);
			wr(A_CTL, 8'hC4);
		end
		wr(A_OWN, {own, 1'b0});
		addr(TWS_GC_ADDR, 1'b1);
		m.stop();
		addr({own, 1'b1}, 1'b0);
		m.stop();
		rdchk(A_STA, TWS_ST_NONE);
		$display("test general call done");
		@(posedge clk);
		deep_sleep <= 1'b1;
		addr({own, 1'b0}, 1'b0);
		wait_flag(TWS_ST_OWN_ACK);
		chk1(wake, 1'b1);
		chk1(scl_oe, 1'b1);
		wr(A_CTL, 8'hC4);
		repeat (4) @(posedge clk);
		chk1(wake, 1'b0);
		chk1(scl_oe, 1'b0);
		deep_sleep <= 1'b0;
		m.stop();
		wait_flag(TWS_ST_STOP);
		wr(A_CTL, 8'hC4);
		$display("test sleep done");
		tally_and_finish();
	end

	// whole run is about a dozen microseconds
	initial begin
		#300000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
